/* File: design/sel_pkg.sv */
// package for the redundant signal selector: widths, register map, types
// assumes a single 10 MHz clock domain and a plain register port
package sel_pkg;
  localparam int VAL_W = 16;
  localparam int NCH = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // register map (byte offsets)
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ = 4'h8;
  localparam logic [ADDR_W-1:0] REG_MASK = 4'hC;
  // control fields
  localparam int CTRL_CFG_LSB = 0;   // 2 bits: inputs in use
  localparam int CTRL_PICK_BIT = 2;  // operator choice, two-input mode
  localparam int CTRL_LIM_LSB = 16;  // 16-bit upper validity limit
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [VAL_W-1:0] LIM_RESET = 16'hFFFF;
  // irq bits
  localparam int IRQ_BAD = 0;
  localparam int IRQ_MANUAL = 1;
  localparam int IRQ_W = 2;
  typedef enum logic [1:0] {CFG_FOUR, CFG_TWO, CFG_THREE, CFG_RSVD} cfg_e;
  typedef struct packed {
    logic [VAL_W-1:0] value;
    logic status_ok;
  } chan_s;
endpackage

/* File: design/signal_selector.sv */
// redundant signal selector: qualifies up to four channels and picks the
// control value by median, average, operator choice or single survivor
// assumes channel inputs are asynchronous and need synchronising
`timescale 1ns/1ps
`default_nettype none
module signal_selector
  import sel_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // redundant channels
  input wire chan_s [NCH-1:0] chan_in,
  input wire logic [NCH-1:0] bypass_in,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  // controller and workstation
  output logic [VAL_W-1:0] ctrl_value,
  output logic ctrl_valid,
  output logic manual_mode,
  output logic operator_alert,
  output logic irq
);
  // ==========================================================
  // input synchronisers
  chan_s [NCH-1:0] sync1, sync2;
  logic [NCH-1:0] byp1, byp2;
  // two stages since channels arrive from another domain
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      byp1 <= '0;
      byp2 <= '0;
    end else begin
      sync1 <= chan_in;
      sync2 <= sync1;
      byp1 <= bypass_in;
      byp2 <= byp1;
    end
  end

  // ==========================================================
  // registers
  logic [1:0] cfg, next_cfg;
  logic pick, next_pick;
  logic [VAL_W-1:0] lim, next_lim;
  logic [IRQ_W-1:0] irq_st, next_irq_st, mask, next_mask;
  logic [DATA_W-1:0] next_rdata;
  logic [NCH-1:0] good, good_q, next_good_q;
  logic manual_now, next_manual, next_alert;
  logic [VAL_W-1:0] next_value;
  logic next_valid;

  // ==========================================================
  // qualification
  logic [NCH-1:0] used;
  always_comb begin
    unique case (cfg_e'(cfg))
      CFG_TWO: used = 4'h3;
      CFG_THREE: used = 4'h7;
      default: used = 4'hF;
    endcase
  end
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      good[i] = used[i] & sync2[i].status_ok & ~byp2[i] &
                (sync2[i].value <= lim);
    end
  end

  // ==========================================================
  // sort good values: bad ones pushed to top as max so they drop out
  logic [VAL_W-1:0] v [NCH];
  logic [VAL_W-1:0] s [NCH];
  logic [2:0] ngood;
  always_comb begin
    logic [VAL_W-1:0] t;
    t = '0;
    ngood = '0;
    for (int i = 0; i < NCH; i++) begin
      v[i] = good[i] ? sync2[i].value : '1;
      ngood = ngood + 3'(good[i]);
    end
    s = v;
    for (int a = 0; a < NCH - 1; a++) begin
      for (int b = 0; b < NCH - 1 - a; b++) begin
        if (s[b] > s[b+1]) begin
          t = s[b];
          s[b] = s[b+1];
          s[b+1] = t;
        end
      end
    end
  end

  // averaging in one extra bit avoids overflow
  function automatic logic [VAL_W-1:0] avg2(input logic [VAL_W-1:0] x,
                                            input logic [VAL_W-1:0] y);
    logic [VAL_W:0] sum;
    sum = {1'b0, x} + {1'b0, y};
    return sum[VAL_W:1];
  endfunction

  // ==========================================================
  // selection
  always_comb begin
    next_value = ctrl_value;
    next_valid = 1'b1;
    manual_now = 1'b0;
    case (ngood)
      3'd4: begin
        next_value = avg2(s[1], s[2]);
      end
      3'd3: begin
        next_value = s[1];
      end
      3'd2: begin
        if (cfg_e'(cfg) == CFG_TWO) begin
          next_value = pick ? sync2[1].value : sync2[0].value;
        end else begin
          next_value = avg2(s[0], s[1]);
        end
      end
      3'd1: begin
        next_value = s[0];
      end
      default: begin
        manual_now = 1'b1;
        next_valid = 1'b0;
      end
    endcase
    if (manual_now) begin
      next_value = '0;
    end
    next_manual = manual_now;
    // alert only for three and four input setups
    next_alert = manual_now & (cfg_e'(cfg) != CFG_TWO);
  end

  // ==========================================================
  // register port and interrupt status
  always_comb begin
    next_cfg = cfg;
    next_pick = pick;
    next_lim = lim;
    next_mask = mask;
    next_irq_st = irq_st;
    next_good_q = good;
    next_rdata = '0;
    if (wr) begin
      if (addr == REG_CTRL) begin
        next_cfg = wdata[CTRL_CFG_LSB +: 2];
        next_pick = wdata[CTRL_PICK_BIT];
        next_lim = wdata[CTRL_LIM_LSB +: VAL_W];
      end else if (addr == REG_IRQ) begin
        next_irq_st = irq_st & ~wdata[IRQ_W-1:0];
      end else if (addr == REG_MASK) begin
        next_mask = wdata[IRQ_W-1:0];
      end
    end
    // good to bad notifies
    // set wins over a same-cycle clear
    if (|(good_q & ~good)) begin
      next_irq_st[IRQ_BAD] = 1'b1;
    end
    if (manual_now & ~manual_mode) begin
      next_irq_st[IRQ_MANUAL] = 1'b1;
    end
    if (rd) begin
      if (addr == REG_CTRL) begin
        next_rdata[CTRL_CFG_LSB +: 2] = cfg;
        next_rdata[CTRL_PICK_BIT] = pick;
        next_rdata[CTRL_LIM_LSB +: VAL_W] = lim;
      end else if (addr == REG_STATUS) begin
        next_rdata[NCH-1:0] = good;
        next_rdata[4 +: 3] = ngood;
        next_rdata[8] = manual_mode;
        next_rdata[16 +: VAL_W] = ctrl_value;
      end else if (addr == REG_IRQ) begin
        next_rdata[IRQ_W-1:0] = irq_st;
      end else if (addr == REG_MASK) begin
        next_rdata[IRQ_W-1:0] = mask;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= CFG_RESET;
      pick <= 1'b0;
      lim <= LIM_RESET;
      mask <= '0;
      irq_st <= '0;
      good_q <= '0;
      rdata <= '0;
      ctrl_value <= '0;
      ctrl_valid <= 1'b0;
      manual_mode <= 1'b0;
      operator_alert <= 1'b0;
    end else begin
      cfg <= next_cfg;
      pick <= next_pick;
      lim <= next_lim;
      mask <= next_mask;
      irq_st <= next_irq_st;
      good_q <= next_good_q;
      rdata <= next_rdata;
      ctrl_value <= next_value;
      ctrl_valid <= next_valid;
      manual_mode <= next_manual;
      operator_alert <= next_alert;
    end
  end

  // level interrupt from unmasked sticky bits
  assign irq = |(irq_st & mask);
endmodule
`default_nettype wire

/* File: test/sel_checker.sv */
// port assertions for the signal selector
// assumes one clock domain; bound at the foot
`timescale 1ns/1ps
`default_nettype none
module sel_checker
  import sel_pkg::*;
(
  // clock, reset, stimulus
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire chan_s [NCH-1:0] chan_in,
  input wire logic [NCH-1:0] bypass_in,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic wr,
  input wire logic rd,
  // results
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [VAL_W-1:0] ctrl_value,
  input wire logic ctrl_valid,
  input wire logic manual_mode,
  input wire logic operator_alert
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ====
  // sync and output flops settle in three edges; valid, drift and bypass checks wait seven past reset
  sequence quiet; !wr && $stable(chan_in) && $stable(bypass_in); endsequence
  sequence dark; &bypass_in && $past(arst_n, 7); endsequence
  sequence st_rd; rd && addr == REG_STATUS; endsequence
  chk_manual_blank: assert property (manual_mode |->
    !ctrl_valid && ctrl_value == 16'h0000) else $error("value in manual");
  chk_alert_manual: assert property (operator_alert |-> manual_mode)
    else $error("alert outside manual");
  chk_valid_excl: assert property ($past(arst_n, 7) |->
    ctrl_valid != manual_mode) else $error("valid and manual agree");
  chk_idle_read: assert property (!rd |=> rdata == 32'h0000_0000)
    else $error("read data outside slot");
  chk_status_value: assert property (st_rd |=>
    rdata[31:16] == $past(ctrl_value)) else $error("status value stale");
  chk_good_count: assert property (st_rd |=>
    rdata[6:4] == 3'($countones(rdata[3:0])) &&
    rdata[8] == (rdata[6:4] == 3'h0)) else $error("good count wrong");
  chk_settled_out: assert property (quiet [*4] ##0 $past(arst_n, 7)
    |=> $stable(ctrl_value) && $stable(manual_mode)) else $error("drift");
  chk_all_bypass: assert property (dark [*4] |-> manual_mode)
    else $error("bypass not excluded");
endmodule
bind signal_selector sel_checker chk_i (.ref_clk(ref_clk), .arst_n(arst_n),
  .chan_in(chan_in), .bypass_in(bypass_in), .addr(addr), .wr(wr), .rd(rd),
  .rdata(rdata), .ctrl_value(ctrl_value), .ctrl_valid(ctrl_valid),
  .manual_mode(manual_mode), .operator_alert(operator_alert));
`default_nettype wire

/* File: test/loop_station.sv */
// far side: operator desk counting alerts
// assumes the alert is a registered level
`timescale 1ns/1ps
`default_nettype none
module loop_station (
  // clock, reset, alert in
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic operator_alert,
  // desk tally
  output var int alerts
);
  logic seen;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      seen <= 1'b0;
      alerts <= 0;
    end else begin
      seen <= operator_alert;
      if (operator_alert && !seen) alerts <= alerts + 1;
    end
  end
endmodule
`default_nettype wire

/* File: test/redundant_signal_selector_test.sv */
// bench: random channel sets against a queue model
// assumes 3-edge output latency and the sel_pkg map
`timescale 1ns/1ps
`default_nettype none
module redundant_signal_selector_test;
  import sel_pkg::*;
  logic ref_clk, arst_n, wr, rd, ctrl_valid, manual_mode, operator_alert, irq;
  chan_s [NCH-1:0] chan_in;
  logic [NCH-1:0] bypass_in;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic [VAL_W-1:0] ctrl_value;
  int failures, tests_run, alerts, e, n, cfg, pick, gm;
  int val[4], st[4], by[4], g[$];
  signal_selector dut (.ref_clk(ref_clk), .arst_n(arst_n), .chan_in(chan_in),
    .bypass_in(bypass_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ctrl_value(ctrl_value), .ctrl_valid(ctrl_valid),
    .manual_mode(manual_mode), .operator_alert(operator_alert), .irq(irq));
  loop_station far (.ref_clk(ref_clk), .arst_n(arst_n),
    .operator_alert(operator_alert), .alerts(alerts));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bus cycle; read data taken while it stands, clear of the edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] x);
    @(posedge ref_clk);
    addr <= a;
    wdata <= x;
    wr <= w;
    rd <= !w;
    @(posedge ref_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // apply channels, then wait out sync and output edges
  task drive;
    @(posedge ref_clk);
    for (int k = 0; k < 4; k++) begin
      chan_in[k] <= {val[k][15:0], st[k][0]};
      bypass_in[k] <= by[k][0];
    end
    repeat (4) @(posedge ref_clk);
  endtask
  // ====
  // queue model: qualify, sort, pick by good count
  task check_out;
    g = {};
    gm = 0;
    n = (cfg == 1) ? 2 : (cfg == 2) ? 3 : 4;
    for (int k = 0; k < n; k++)
      if (st[k] != 0 && by[k] == 0 && val[k] <= 'hC000) begin
        g.push_back(val[k]);
        gm |= 1 << k;
      end
    g.sort();
    case (g.size())
      0: e = 0;
      1: e = g[0];
      2: e = (cfg == 1) ? val[pick] : (g[0] + g[1]) >> 1;
      3: e = g[1];
      default: e = (g[1] + g[2]) >> 1;
    endcase
    chk(ctrl_value, e);
    chk({ctrl_valid, manual_mode, operator_alert},
      {gm != 0, gm == 0, gm == 0 && cfg != 1});
    bus(1'b0, REG_STATUS, 0);
    chk(d, {e[15:0], 7'h00, gm == 0, 1'b0, 3'(g.size()), 4'(gm)});
  endtask
  initial begin
    arst_n = 1'b0;
    {wr, rd, addr, wdata, bypass_in, chan_in} = '0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    void'($urandom(91));
    for (int t = 0; t < 48; t++) begin
      cfg = t % 4;
      pick = $urandom % 2;
      // operator choice rides in the control word
      bus(1'b1, REG_CTRL, {16'hC000, 13'h0000, pick[0], cfg[1:0]});
      for (int k = 0; k < 4; k++) begin
        val[k] = $urandom % 65536;
        st[k] = (t % 8 != 7) && ($urandom % 4 != 0);
        by[k] = $urandom % 6 == 0;
      end
      drive;
      check_out;
    end
    // interrupt raised, masked, cleared
    cfg = 0;
    val = '{1, 17, 33, 49};
    st = '{1, 1, 1, 1};
    by = '{0, 0, 0, 0};
    bus(1'b1, REG_CTRL, 32'hC000_0000);
    drive;
    bus(1'b1, REG_IRQ, 32'h0000_0003);
    bus(1'b1, REG_MASK, 32'h0000_0001);
    chk(irq, 0);
    by[2] = 1;
    drive;
    check_out;
    chk(irq, 1);
    bus(1'b1, REG_MASK, 0);
    chk(irq, 0);
    bus(1'b1, REG_IRQ, 32'h0000_0001);
    bus(1'b0, REG_IRQ, 0);
    chk(d, 0);
    by = '{1, 1, 1, 1};
    drive;
    check_out;
    bus(1'b0, REG_IRQ, 0);
    chk(d, 3);
    chk(alerts != 0, 1);
    bus(1'b0, 4'h2, 0);
    chk(d, 0);
    wrap_up;
  end
  initial begin
    repeat (8000) @(posedge ref_clk);
    failures++;
    wrap_up;
  end
  task wrap_up;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
endmodule
`default_nettype wire
